/* File: src/rd_path_if.sv */
`timescale 1ns/1ps
interface rd_path_if;
	logic                    issue;
	logic [tsm_pkg::LAT_W-1:0] lat;
	logic                    done;
	logic                    pending;
	logic                    pend_nxt;
	logic                    cap;

	modport ctrl  (output issue, output lat, output cap, input done, input pending, input pend_nxt);
	modport track (input issue, input lat, output done, output pending, output pend_nxt);
	modport samp  (input cap);
endinterface : rd_path_if

/* File: src/read_sampler.sv */
`timescale 1ns/1ps
module read_sampler (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	rd_path_if.samp                          rp,
	input  wire logic [tsm_pkg::DATA_W-1:0]  dq_i,
	output logic                             rsp_valid_r,
	output logic      [tsm_pkg::DATA_W-1:0]  rsp_data_r
);
	logic [tsm_pkg::DATA_W-1:0] dq_meta_r;
	logic [tsm_pkg::DATA_W-1:0] dq_sync_r;
	logic                       cap_d1_r;
	logic                       cap_d2_r;
	logic                       rsp_valid_nxt;
	logic [tsm_pkg::DATA_W-1:0] rsp_data_nxt;

	// pin data passes two flops; the capture mark is delayed to line up with it
	always_comb begin
		rsp_valid_nxt = cap_d2_r;
		rsp_data_nxt  = cap_d2_r ? dq_sync_r : rsp_data_r;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dq_meta_r   <= '0;
			dq_sync_r   <= '0;
			cap_d1_r    <= 1'b0;
			cap_d2_r    <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= '0;
		end else begin
			dq_meta_r   <= dq_i;
			dq_sync_r   <= dq_meta_r;
			cap_d1_r    <= rp.cap;
			cap_d2_r    <= cap_d1_r;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r  <= rsp_data_nxt;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_rsp_after_cap: assert property (rp.cap |-> ##3 rsp_valid_r)
		else $error("read data not returned three cycles after capture");
endmodule : read_sampler

/* File: src/read_tracker.sv */
`timescale 1ns/1ps
module read_tracker (
	input wire logic sys_clk,
	input wire logic rst,
	rd_path_if.track rp
);
	logic [tsm_pkg::PIPE_DEPTH-1:0] busy_r;
	logic [tsm_pkg::PIPE_DEPTH-1:0] busy_nxt;
	logic [tsm_pkg::PIPE_DEPTH-1:0] lat_mask;
	logic [tsm_pkg::LAT_W-1:0]      eff_lat;

	// a latency of zero is taken as one; the latency is fixed, never data driven
	assign eff_lat = (rp.lat == '0) ? 3'h1 : rp.lat;

	// one mask bit per pipeline slot still inside the read latency
	for (genvar i = 0; i < tsm_pkg::PIPE_DEPTH; i++) begin : g_mask
		assign lat_mask[i] = (i < int'(eff_lat));
	end

	// each address phase enters a slot and walks out after the latency
	always_comb begin
		busy_nxt = {busy_r[tsm_pkg::PIPE_DEPTH-2:0], rp.issue} & lat_mask;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_r <= '0;
		end else begin
			busy_r <= busy_nxt;
		end
	end

	assign rp.done     = busy_r[eff_lat - 3'h1];  // this edge ends a pipelined read
	assign rp.pending  = |busy_r;
	assign rp.pend_nxt = |busy_nxt;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_lat_two_done: assert property (rp.issue && rp.lat == 3'h2 |-> ##2 rp.done)
		else $error("pipelined read not completed after two cycles");
endmodule : read_tracker

/* File: src/tristate_memory_port.sv */
`timescale 1ns/1ps
module tristate_memory_port (
	input  wire logic                             sys_clk,
	input  wire logic                             rst,
	input  wire logic                             cfg_pipelined,
	input  wire logic                             cfg_cs_through_latency,
	input  wire logic [tsm_pkg::LAT_W-1:0]        cfg_read_latency,
	input  wire logic [tsm_pkg::CNT_W-1:0]        cfg_setup_cycles,
	input  wire logic [tsm_pkg::CNT_W-1:0]        cfg_wait_cycles,
	input  wire logic [tsm_pkg::CNT_W-1:0]        cfg_hold_cycles,
	input  wire logic                             req_valid,
	input  wire logic                             req_write,
	input  wire logic [tsm_pkg::BYTE_ADDR_W-1:0]  req_addr,
	input  wire logic [tsm_pkg::DATA_W-1:0]       req_wdata,
	input  wire logic [tsm_pkg::LANES-1:0]        req_lanes,
	output logic                                  req_ready_r,
	output logic                                  rsp_valid_r,
	output logic      [tsm_pkg::DATA_W-1:0]       rsp_data_r,
	output logic      [tsm_pkg::MEM_ADDR_W-1:0]   mem_addr_r,
	input  wire logic [tsm_pkg::DATA_W-1:0]       mem_dq_i,
	output logic      [tsm_pkg::DATA_W-1:0]       mem_dq_o_r,
	output logic                                  mem_dq_oe_n_r,
	output logic                                  mem_cs_n_r,
	output logic                                  mem_rd_n_r,
	output logic                                  mem_oe_n_r,
	output logic                                  mem_we_n_r,
	output logic      [tsm_pkg::LANES-1:0]        mem_be_n_r
);
	tsm_pkg::xfer_state_t             state_r;
	tsm_pkg::xfer_state_t             state_nxt;
	logic [tsm_pkg::CNT_W-1:0]        cnt_r;
	logic [tsm_pkg::CNT_W-1:0]        cnt_nxt;
	logic                             write_r;
	logic                             write_nxt;
	logic [tsm_pkg::LANES-1:0]        lanes_r;
	logic [tsm_pkg::LANES-1:0]        lanes_nxt;
	logic [tsm_pkg::MEM_ADDR_W-1:0]   addr_nxt;
	logic [tsm_pkg::DATA_W-1:0]       wdata_nxt;
	logic                             take;
	logic                             np_cap;
	logic                             wr_phase;
	logic                             rd_np;
	logic                             rd_strobe;
	logic                             oe_on;
	logic                             cs_on;
	logic                             we_on;
	logic                             ready_nxt;
	logic                             dq_oe_n_nxt;
	logic                             cs_n_nxt;
	logic                             rd_n_nxt;
	logic                             oe_n_nxt;
	logic                             we_n_nxt;
	logic [tsm_pkg::LANES-1:0]        be_n_nxt;

	rd_path_if rp ();

	read_tracker u_tracker (
		.sys_clk (sys_clk),
		.rst     (rst),
		.rp      (rp.track)
	);

	read_sampler u_sampler (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.rp          (rp.samp),
		.dq_i        (mem_dq_i),
		.rsp_valid_r (rsp_valid_r),
		.rsp_data_r  (rsp_data_r)
	);

	// a pipelined read counts as issued at the edge that ends its address phase
	assign rp.issue = (state_r == tsm_pkg::ST_PREAD);
	assign rp.lat   = cfg_read_latency;
	assign rp.cap   = cfg_pipelined ? rp.done : np_cap;

	// a write is refused while any pipelined read may still return data
	assign take = req_valid & req_ready_r
		& (~req_write | ((state_r == tsm_pkg::ST_IDLE) & ~rp.pending));

	// transfer sequencer: one single transfer per request, no bursts
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		write_nxt = write_r;
		lanes_nxt = lanes_r;
		addr_nxt  = mem_addr_r;
		wdata_nxt = mem_dq_o_r;
		np_cap    = 1'b0;
		unique case (state_r)
			tsm_pkg::ST_IDLE, tsm_pkg::ST_PREAD: begin
				state_nxt = tsm_pkg::ST_IDLE;
				if (take) begin
					// byte address in, word address out
					addr_nxt  = req_addr[tsm_pkg::BYTE_ADDR_W-1:tsm_pkg::EXT_ADDR_LSB];
					write_nxt = req_write;
					lanes_nxt = req_lanes;
					if (req_write) begin
						wdata_nxt = req_wdata;
					end
					if (cfg_pipelined && !req_write) begin
						state_nxt = tsm_pkg::ST_PREAD;
					end else if (cfg_setup_cycles != '0) begin
						state_nxt = tsm_pkg::ST_SETUP;
						cnt_nxt   = cfg_setup_cycles - 4'h1;
					end else begin
						state_nxt = tsm_pkg::ST_ACCESS;
						cnt_nxt   = cfg_wait_cycles;
					end
				end
			end
			tsm_pkg::ST_SETUP: begin
				if (cnt_r == '0) begin
					state_nxt = tsm_pkg::ST_ACCESS;
					cnt_nxt   = cfg_wait_cycles;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			tsm_pkg::ST_ACCESS: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 4'h1;
				end else begin
					// timing is purely counted; nothing from the memory can stretch it
					np_cap = ~write_r;
					if (write_r && cfg_hold_cycles != '0) begin
						state_nxt = tsm_pkg::ST_HOLD;
						cnt_nxt   = cfg_hold_cycles - 4'h1;
					end else begin
						state_nxt = tsm_pkg::ST_IDLE;
					end
				end
			end
			tsm_pkg::ST_HOLD: begin
				if (cnt_r == '0) begin
					state_nxt = tsm_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
		endcase
	end

	// pin levels decoded from the next state, so every pin leaves a flop
	always_comb begin
		wr_phase  = write_nxt & (state_nxt inside {tsm_pkg::ST_SETUP, tsm_pkg::ST_ACCESS,
			tsm_pkg::ST_HOLD});
		rd_np     = ~write_nxt & (state_nxt == tsm_pkg::ST_ACCESS);
		rd_strobe = rd_np | (state_nxt == tsm_pkg::ST_PREAD);
		// pipelined: enable from address phase until no read is pending
		oe_on     = cfg_pipelined ? ((state_nxt == tsm_pkg::ST_PREAD) | rp.pend_nxt)
			: rd_np;
		// one select timing for all pipelined reads, fixed by a static input
		if (cfg_pipelined) begin
			cs_on = wr_phase | (cfg_cs_through_latency ? oe_on
				: (state_nxt == tsm_pkg::ST_PREAD));
		end else begin
			cs_on = wr_phase | (~write_nxt & (state_nxt inside {tsm_pkg::ST_SETUP,
				tsm_pkg::ST_ACCESS}));
		end
		we_on       = write_nxt & (state_nxt == tsm_pkg::ST_ACCESS);
		// active-low pin levels
		cs_n_nxt    = ~cs_on;
		rd_n_nxt    = ~rd_strobe;
		oe_n_nxt    = ~oe_on;
		we_n_nxt    = ~we_on;
		be_n_nxt    = ~({tsm_pkg::LANES{we_on}} & lanes_nxt);
		dq_oe_n_nxt = ~wr_phase;  // drive the shared bus only for writes
		ready_nxt   = (state_nxt inside {tsm_pkg::ST_IDLE, tsm_pkg::ST_PREAD});
	end

	// reset parks every strobe high and floats the data driver
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r       <= tsm_pkg::ST_IDLE;
			cnt_r         <= '0;
			write_r       <= 1'b0;
			lanes_r       <= '0;
			mem_addr_r    <= '0;
			mem_dq_o_r    <= '0;
			mem_dq_oe_n_r <= tsm_pkg::STROBE_OFF_N;
			mem_cs_n_r    <= tsm_pkg::STROBE_OFF_N;
			mem_rd_n_r    <= tsm_pkg::STROBE_OFF_N;
			mem_oe_n_r    <= tsm_pkg::STROBE_OFF_N;
			mem_we_n_r    <= tsm_pkg::STROBE_OFF_N;
			mem_be_n_r    <= {tsm_pkg::LANES{tsm_pkg::STROBE_OFF_N}};
			req_ready_r   <= tsm_pkg::READY_RST;
		end else begin
			state_r       <= state_nxt;
			cnt_r         <= cnt_nxt;
			write_r       <= write_nxt;
			lanes_r       <= lanes_nxt;
			mem_addr_r    <= addr_nxt;
			mem_dq_o_r    <= wdata_nxt;
			mem_dq_oe_n_r <= dq_oe_n_nxt;
			mem_cs_n_r    <= cs_n_nxt;
			mem_rd_n_r    <= rd_n_nxt;
			mem_oe_n_r    <= oe_n_nxt;
			mem_we_n_r    <= we_n_nxt;
			mem_be_n_r    <= be_n_nxt;
			req_ready_r   <= ready_nxt;
		end
	end

	// checker helper: counts hold cycles between write strobe release and bus release
	logic                             hold_seen_r;
	logic                             hold_seen_nxt;
	logic [tsm_pkg::CNT_W-1:0]        hold_len_r;
	logic [tsm_pkg::CNT_W-1:0]        hold_len_nxt;

	// a counter instead of a repetition: hold counts reach fifteen cycles
	always_comb begin
		hold_seen_nxt = hold_seen_r;
		hold_len_nxt  = hold_len_r;
		if (!mem_we_n_r) begin
			hold_seen_nxt = 1'b1;
			hold_len_nxt  = '0;
		end else if (hold_seen_r && !mem_dq_oe_n_r) begin
			hold_len_nxt = hold_len_r + 4'h1;
		end
		if (mem_dq_oe_n_r) begin
			hold_seen_nxt = 1'b0;  // bus released, the write is over
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hold_seen_r <= 1'b0;
			hold_len_r  <= '0;
		end else begin
			hold_seen_r <= hold_seen_nxt;
			hold_len_r  <= hold_len_nxt;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// checks on pins, handshake and internal read tracking; none watches the memory's returned data
	a_oe_reads_only: assert property (!mem_oe_n_r |-> mem_we_n_r && mem_dq_oe_n_r)
		else $error("output enable asserted outside a read");
	a_we_drives_bus: assert property (!mem_we_n_r |-> !mem_dq_oe_n_r && mem_oe_n_r)
		else $error("write strobe without the port driving data");
	a_np_oe_rd: assert property (!cfg_pipelined |-> mem_oe_n_r == mem_rd_n_r)
		else $error("unpipelined enable differs from read strobe");
	a_lane_strobes: assert property (mem_we_n_r |-> mem_be_n_r == {tsm_pkg::LANES{1'b1}})
		else $error("lane strobe active without write strobe");
	a_rd_addr_phase: assert property (cfg_pipelined && $fell(mem_rd_n_r)
		&& !req_valid |=> mem_rd_n_r)
		else $error("pipelined read strobe held into data phase");
	a_cs_through: assert property (cfg_pipelined && cfg_cs_through_latency && mem_dq_oe_n_r
		|-> mem_cs_n_r == mem_oe_n_r)
		else $error("select does not follow output enable");
	a_cs_addr_only: assert property (cfg_pipelined && !cfg_cs_through_latency
		&& mem_dq_oe_n_r |-> mem_cs_n_r == mem_rd_n_r)
		else $error("select does not follow read strobe");
	a_oe_at_cap: assert property (cfg_pipelined && rp.cap |-> !mem_oe_n_r)
		else $error("pipelined capture edge without output enable");
	a_write_no_pend: assert property (!mem_dq_oe_n_r |-> !rp.pending && mem_oe_n_r)
		else $error("write data driven while reads pending");
	a_hold_addr: assert property ($rose(mem_we_n_r) && cfg_hold_cycles != '0
		|-> $stable(mem_addr_r) && !mem_dq_oe_n_r && $stable(mem_dq_o_r))
		else $error("address or data dropped during hold");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> mem_cs_n_r && mem_oe_n_r
		&& mem_we_n_r && mem_dq_oe_n_r)
		else $error("strobes active after reset");
	a_hold_len: assert property ($rose(mem_dq_oe_n_r) && hold_seen_r
		|-> hold_len_r == cfg_hold_cycles)
		else $error("write hold length differs from configured count");
	a_addr_map: assert property (take |=> mem_addr_r == $past(req_addr) >> tsm_pkg::EXT_ADDR_LSB)
		else $error("memory address not taken from the byte address");
	a_one_xfer: assert property (take && (req_write || !cfg_pipelined) |=> !req_ready_r)
		else $error("second request accepted during a single transfer");

	// main scenarios that the bench is expected to reach
	c_pipe_read: cover property (cfg_pipelined && rp.issue ##1 rp.issue);
	c_np_read: cover property (!cfg_pipelined && rp.cap);
	c_write_hold: cover property ($rose(mem_we_n_r) && !mem_dq_oe_n_r);
	c_sel_addr_phase: cover property (cfg_pipelined && !cfg_cs_through_latency && rp.cap);
	c_write_waits: cover property (req_valid && req_write && req_ready_r && rp.pending);
endmodule : tristate_memory_port

/* File: src/tsm_pkg.sv */
package tsm_pkg;
	// data path shape, fixed for this port
	localparam int DATA_W      = 32;
	localparam int LANES       = DATA_W / 8;
	localparam int BYTE_ADDR_W = 20;
	localparam int CNT_W       = 4;
	localparam int LAT_W       = 3;
	localparam int PIPE_DEPTH  = 8;

	// byte-address bit that feeds the memory's lowest address line
	function automatic int ext_addr_lsb_f(input int width);
		int lsb;
		lsb = 0;
		for (int i = 0; i < 8; i++) begin
			if (width > (8 << i)) begin
				lsb = i + 1;
			end
		end
		return lsb;
	endfunction : ext_addr_lsb_f

	localparam int EXT_ADDR_LSB = ext_addr_lsb_f(DATA_W);
	localparam int MEM_ADDR_W   = BYTE_ADDR_W - EXT_ADDR_LSB;

	// reset and idle levels of the active-low pin strobes, and the reset level of ready
	localparam logic STROBE_OFF_N = 1'b1;
	localparam logic READY_RST    = 1'b0;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_SETUP  = 5'b00010,
		ST_ACCESS = 5'b00100,
		ST_HOLD   = 5'b01000,
		ST_PREAD  = 5'b10000
	} xfer_state_t;
endpackage : tsm_pkg

/* File: verification/mem_model.sv */
`timescale 1ns/1ps
// behavioural memory chip on the shared address and data lines
module mem_model (
	input wire logic                           sys_clk,
	input wire logic                           cfg_pipelined,
	input wire logic [tsm_pkg::LAT_W-1:0]      cfg_read_latency,
	input wire logic [tsm_pkg::MEM_ADDR_W-1:0] mem_addr_r,
	input wire logic [tsm_pkg::DATA_W-1:0]     bus_dq,
	input wire logic                           mem_cs_n_r,
	input wire logic                           mem_rd_n_r,
	input wire logic                           mem_oe_n_r,
	input wire logic                           mem_we_n_r,
	input wire logic [tsm_pkg::LANES-1:0]      mem_be_n_r,
	output logic     [tsm_pkg::DATA_W-1:0]     chip_dq
);
	logic [31:0] mem [16];
	logic [4:0]  pipe [8];
	logic [7:0]  junk;
	int          slot;

	initial begin
		junk = 8'h00;
		foreach (pipe[i]) pipe[i] = 5'h00;
	end

	// synchronous read address capture and per-lane writes
	always @(posedge sys_clk) begin
		junk <= junk + 8'h3b;
		pipe[0] <= {~(mem_cs_n_r | mem_rd_n_r), mem_addr_r[3:0]};
		for (int i = 1; i < 8; i++) pipe[i] <= pipe[i-1];
		for (int i = 0; i < 4; i++) begin
			if (!mem_cs_n_r && !mem_we_n_r && !mem_be_n_r[i]) begin
				mem[mem_addr_r[3:0]][8*i+:8] <= bus_dq[8*i+:8];
			end
		end
	end

	// drive only while output enable is low; released lines show a moving pattern
	always_comb begin
		slot = (cfg_read_latency == 0) ? 0 : int'(cfg_read_latency) - 1;
		chip_dq = {4{junk}};
		if (!mem_oe_n_r && !cfg_pipelined) chip_dq = mem[mem_addr_r[3:0]];
		if (!mem_oe_n_r && cfg_pipelined && pipe[slot][4]) chip_dq = mem[pipe[slot][3:0]];
	end
endmodule : mem_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
	logic                            sys_clk, rst, cfg_pipelined, cfg_cs_through_latency;
	logic [tsm_pkg::LAT_W-1:0]       cfg_read_latency;
	logic [tsm_pkg::CNT_W-1:0]       cfg_setup_cycles, cfg_wait_cycles, cfg_hold_cycles;
	logic                            req_valid, req_write, req_ready_r, rsp_valid_r;
	logic [tsm_pkg::BYTE_ADDR_W-1:0] req_addr;
	logic [tsm_pkg::DATA_W-1:0]      req_wdata, rsp_data_r, mem_dq_o_r, chip_dq, bus_dq;
	logic [tsm_pkg::LANES-1:0]       req_lanes, mem_be_n_r;
	logic [tsm_pkg::MEM_ADDR_W-1:0]  mem_addr_r;
	logic                            mem_dq_oe_n_r, mem_cs_n_r, mem_rd_n_r, mem_oe_n_r, mem_we_n_r;
	int                              n_fail, n_compared, seed;
	logic [31:0]                     shadow [16];
	logic [31:0]                     exp_q [$];
	logic [31:0]                     last_a, last_d, r;
	logic [3:0]                      last_l;

	// wire level of the shared data lines from both drivers
	assign bus_dq = mem_dq_oe_n_r ? chip_dq : mem_dq_o_r;

	tristate_memory_port i_dut (.sys_clk, .rst, .cfg_pipelined, .cfg_cs_through_latency,
		.cfg_read_latency, .cfg_setup_cycles, .cfg_wait_cycles, .cfg_hold_cycles, .req_valid,
		.req_write, .req_addr, .req_wdata, .req_lanes, .req_ready_r, .rsp_valid_r, .rsp_data_r,
		.mem_addr_r, .mem_dq_i(bus_dq), .mem_dq_o_r, .mem_dq_oe_n_r, .mem_cs_n_r, .mem_rd_n_r,
		.mem_oe_n_r, .mem_we_n_r, .mem_be_n_r);

	mem_model i_mem (.sys_clk, .cfg_pipelined, .cfg_read_latency, .mem_addr_r, .bus_dq,
		.mem_cs_n_r, .mem_rd_n_r, .mem_oe_n_r, .mem_we_n_r, .mem_be_n_r, .chip_dq);

	// free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// word after a write: only the selected byte lanes take the new data
	function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] l);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) if (l[i]) m[8*i+:8] = d[8*i+:8];
		return m;
	endfunction : merge_lanes

	// offer one request and hold it until the port takes it
	task automatic send(input logic w, input logic [31:0] a, input logic [31:0] d,
			input logic [3:0] l);
		logic rdy;
		logic took;
		took = 1'b0;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a[19:0];
		req_wdata = d;
		req_lanes = l;
		for (int k = 0; k < 300 && !took; k++) begin
			@(posedge sys_clk);
			rdy = req_ready_r;
			#1;
			took = rdy && (!w || !req_ready_r);
		end
		if (!took) begin
			n_fail++;
			final_report();
		end else begin
			last_a = a;
			last_d = d;
			last_l = l;
			if (!w) exp_q.push_back(shadow[a[5:2]]);
			else shadow[a[5:2]] = merge_lanes(shadow[a[5:2]], d, l);
		end
	endtask : send

	task automatic rnd_op(input logic w);
		r = $random(seed);
		send(w, r, $random(seed), r[23:20]);
	endtask : rnd_op

	// idle the request and wait until all answers are back
	task automatic drain();
		int k;
		@(negedge sys_clk);
		req_valid = 1'b0;
		for (k = 0; k < 300 && !(exp_q.size() == 0 && req_ready_r === 1'b1); k++) @(negedge sys_clk);
		if (k == 300) begin
			n_fail++;
			final_report();
		end
	endtask : drain

	// pin monitor; read data is compared when the pulse is settled
	always @(negedge sys_clk) begin
		if (!rst) begin
			check("oe_vs_drive", 32'(!mem_oe_n_r && !mem_dq_oe_n_r), 0);
			if (!mem_we_n_r) begin
				check("we_drive", 32'(mem_dq_oe_n_r), 0);
				check("we_addr", 32'(mem_addr_r), 32'(last_a[19:2]));
				check("we_data", mem_dq_o_r, last_d);
				check("lane_strobes", 32'(mem_be_n_r), {28'h0, ~last_l});
			end else check("lanes_idle", 32'(mem_be_n_r), 32'h0f);
			if (!mem_rd_n_r) check("rd_addr", 32'(mem_addr_r), 32'(last_a[19:2]));
			if (!cfg_pipelined) check("oe_is_rd", 32'(mem_oe_n_r), 32'(mem_rd_n_r));
			else if (mem_dq_oe_n_r) check("select", 32'(mem_cs_n_r),
				32'(cfg_cs_through_latency ? mem_oe_n_r : mem_rd_n_r));
			if (rsp_valid_r === 1'b1)
				check("read_data", rsp_data_r, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
		end
	end

	// bound on the whole run
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_fail++;
		final_report();
	end

	// main sequence
	initial begin
		seed = 32'h3343e35d;
		n_fail = 0;
		n_compared = 0;
		{rst, req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, 58'h0};
		{cfg_pipelined, cfg_cs_through_latency, cfg_read_latency} = 5'h00;
		{cfg_setup_cycles, cfg_wait_cycles, cfg_hold_cycles} = 12'h111;
		repeat (4) begin
			@(negedge sys_clk);
			check("reset_idle", {mem_cs_n_r, mem_rd_n_r, mem_oe_n_r, mem_we_n_r,
				mem_dq_oe_n_r}, 32'h1f);
		end
		rst = 1'b0;
		// strobe-timed mode: zero counts first, then random counts
		for (int c = 0; c < 4; c++) begin
			r = $random(seed);
			cfg_setup_cycles = (c == 0) ? 4'h0 : 4'(r[1:0]);
			cfg_wait_cycles = (c == 0) ? 4'h0 : 4'(r[3:2]);
			cfg_hold_cycles = (c == 0) ? 4'h0 : 4'(r[5:4]);
			cfg_cs_through_latency = r[6];
			for (int i = 0; i < 16; i++) begin
				r = $random(seed);
				r[5:2] = 4'(i);
				send(1'b1, r, $random(seed), 4'hf);
			end
			repeat (24) rnd_op(1'($random(seed)));
			drain();
		end
		// fixed-latency mode: each latency, select timing alternating from one latency to the next
		cfg_pipelined = 1'b1;
		for (int l = 0; l < 8; l++) begin
			cfg_read_latency = 3'(l);
			cfg_cs_through_latency = 1'(l);
			repeat (6) rnd_op(1'b0);
			rnd_op(1'b1);
			repeat (3) rnd_op(1'b0);
			drain();
		end
		final_report();
	end
endmodule : tb
